// *** rtl/lti_defines.vh ***
`ifndef LTI_DEFINES_VH
`define LTI_DEFINES_VH
// start and cycle type nibbles
`define LTI_START_TARGET 4'h0
`define LTI_ABORT 4'hF
`define LTI_CT_IO_RD 2'h0
`define LTI_CT_IO_WR 2'h1
`define LTI_CT_DMA_RD 2'h2
`define LTI_CT_DMA_WR 2'h3
`define LTI_SZ_1 2'h0
`define LTI_SZ_2 2'h1
// sync patterns
`define LTI_SYNC_READY 4'h0
`define LTI_SYNC_SHORT 4'h5
`define LTI_SYNC_LONG 4'h6
`define LTI_SYNC_ERROR 4'hA
`define LTI_TAR 4'hF
// decode windows: base, mask of the offset bits
`define LTI_RT_BASE_RST 16'h0A00
`define LTI_RT_MASK 16'h007F
`define LTI_KEY_BASE_RST 16'h0B00
`define LTI_KEY_MASK 16'h001F
`define LTI_KBD_ADDR0 16'h0060
`define LTI_KBD_ADDR1 16'h0064
`define LTI_SYNC_DUE_MAX 3
`endif

// *** rtl/lti_stub.v ***
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// *** rtl/lti_target.v ***
// Function
// - every host-visible register is one byte, via I/O or DMA
// - answer only single-byte I/O read/write and allowed DMA; ignore others
// - DMA of one or two bytes accepted; four-byte DMA rejected
// - active-low bus reset resets the bus interface; the power-event output keeps following pme_req
// - drive encoded request line; no clock-run, power-down or SMI retry
// - open-drain power-event output requests wakeup from S3 or deeper
// - on reads, start sync as soon as the cycle is recognised
// - wait sync repeats until ready, then ready sync 0000
// - one wait pattern per cycle, never switching short and long
// - data follows the clock right after the ready sync
// - DMA wait states use sync 0101
// - I/O wait states use sync 0110
// - sync response starts within three clocks of the sync point
// - during reset device ignores frame, floats lines, request high
// - logical devices decoded in relocatable base-relative windows, except keyboard at fixed ports 0060 and 0064
// - one address may select different registers by direction or state
`include "lti_defines.vh"
`timescale 1ns/1ps
`default_nettype none
module lti_target #(
  parameter DMA_CHAN = 3'd2
) (
  input wire core_clk,
  input wire rst,
  input wire lpc_reset_n,
  input wire lframe_n,
  input wire [3:0] lad_in,
  output reg [3:0] lad_out,
  output reg lad_oe,
  output reg ldrq_n,
  input wire [15:0] rt_base,
  input wire [15:0] key_base,
  input wire dma_req,
  input wire dma_size2,
  input wire dma_dir_wr,
  output reg [15:0] reg_addr,
  output reg reg_wr,
  output reg reg_rd,
  output reg [7:0] reg_wdata,
  output reg [1:0] reg_sel,
  output reg reg_dma,
  input wire [7:0] reg_rdata,
  input wire reg_ready,
  input wire pme_req,
  output reg power_event_request_n,
  output reg power_event_oe
);
  localparam S_IDLE = 4'd0;
  localparam S_TYPE = 4'd1;
  localparam S_ADDR = 4'd2;
  localparam S_WDAT = 4'd3;
  localparam S_TAR1 = 4'd4;
  localparam S_SYNC = 4'd5;
  localparam S_RDAT = 4'd6;
  localparam S_TARB = 4'd7;
  localparam S_DCHN = 4'd8;
  localparam S_DSIZ = 4'd9;
  localparam S_SKIP = 4'd10;
  localparam S_TAR2 = 4'd11;

  // three-stage sampling for the pins; stage 1 only feeds stage 2
  reg [5:0] s1_reg, s2_reg, s3_reg;
  reg [5:0] pin_reg;
  wire [5:0] pin_now = (s2_reg == s3_reg) ? s2_reg : pin_reg;
  wire frame_n = pin_now[5];
  wire bus_rst_n = pin_now[4];
  wire [3:0] lad = pin_now[3:0];

  reg [3:0] state_reg;
  reg [1:0] ctype_reg;
  reg [1:0] size_reg;
  reg [2:0] nib_reg;
  reg [1:0] byte_reg;
  reg [7:0] data_reg;
  reg [1:0] due_reg;
  reg [3:0] wait_pat_reg;
  reg [3:0] dreq_reg;
  reg [2:0] dreq_cnt_reg;
  reg dreq_sent_reg;
  reg [1:0] slot_cnt_reg;

  // bus clock is about a quarter of core_clk; slots realign on every frame fall
  // so the mid-slot sample never drifts onto a nibble edge
  wire frame_fall = !pin_now[5] && pin_reg[5];
  wire slot_en = (slot_cnt_reg == 2'h1);

  // decode of the relocatable windows and fixed keyboard ports
  function [1:0] lti_decode;
    input [15:0] a;
    input [15:0] rb;
    input [15:0] kb;
    begin
      if ((a & ~`LTI_RT_MASK) == (rb & ~`LTI_RT_MASK))
        lti_decode = 2'h1;
      else if ((a & ~`LTI_KEY_MASK) == (kb & ~`LTI_KEY_MASK))
        lti_decode = 2'h2;
      else if (a == `LTI_KBD_ADDR0 || a == `LTI_KBD_ADDR1)
        lti_decode = 2'h3;
      else
        lti_decode = 2'h0;
    end
  endfunction

  wire is_dma = ctype_reg[1];
  wire is_rd = (ctype_reg == `LTI_CT_IO_RD) || (ctype_reg == `LTI_CT_DMA_WR);

  // four core clocks per bus slot by wrap of the two-bit counter
  always @(posedge core_clk or posedge rst) begin
    if (rst)
      slot_cnt_reg <= 2'h0;
    else if (frame_fall)
      slot_cnt_reg <= 2'h0;
    else
      slot_cnt_reg <= slot_cnt_reg + 2'h1;
  end

  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      s1_reg <= 6'h3F;
      s2_reg <= 6'h3F;
      s3_reg <= 6'h3F;
      pin_reg <= 6'h3F;
    end else begin
      s1_reg <= {lframe_n, lpc_reset_n, lad_in};
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      pin_reg <= pin_now;
    end
  end

  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_reg <= S_IDLE;
      ctype_reg <= 2'h0;
      size_reg <= 2'h0;
      nib_reg <= 3'h0;
      byte_reg <= 2'h0;
      data_reg <= 8'h00;
      due_reg <= 2'h0;
      wait_pat_reg <= `LTI_SYNC_LONG;
      lad_out <= `LTI_TAR;
      lad_oe <= 1'b0;
      reg_addr <= 16'h0000;
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      reg_wdata <= 8'h00;
      reg_sel <= 2'h0;
      reg_dma <= 1'b0;
    end else if (!bus_rst_n) begin
      state_reg <= S_IDLE;
      lad_oe <= 1'b0;
      lad_out <= `LTI_TAR;
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
    end else begin
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      if (slot_en && !frame_n) begin
        // frame low restarts decode; also ends a broken cycle
        lad_oe <= 1'b0;
        state_reg <= (lad == `LTI_START_TARGET) ? S_TYPE : S_IDLE;
      end else if (slot_en) begin
        case (state_reg)
          S_IDLE: lad_oe <= 1'b0;
          S_TYPE: begin
            ctype_reg <= lad[3:2];
            nib_reg <= 3'h0;
            byte_reg <= 2'h0;
            reg_dma <= lad[3];
            // memory and bus-master types carry other encodings
            if (lad[1:0] != 2'h0 || lad[3:2] == 2'h3 && lad[1:0] != 2'h0)
              state_reg <= S_SKIP;
            else if (lad[3])
              state_reg <= S_DCHN;
            else
              state_reg <= S_ADDR;
          end
          S_ADDR: begin
            reg_addr <= {reg_addr[11:0], lad};
            nib_reg <= nib_reg + 3'h1;
            if (nib_reg == 3'h3) begin
              reg_sel <= lti_decode({reg_addr[11:0], lad}, rt_base, key_base);
              if (lti_decode({reg_addr[11:0], lad}, rt_base, key_base) == 2'h0)
                state_reg <= S_SKIP;
              else
                state_reg <= is_rd ? S_TAR1 : S_WDAT;
              nib_reg <= 3'h0;
            end
          end
          S_DCHN: begin
            if (lad[2:0] != DMA_CHAN)
              state_reg <= S_SKIP;
            else
              state_reg <= S_DSIZ;
          end
          S_DSIZ: begin
            size_reg <= lad[1:0];
            if (lad[1:0] != `LTI_SZ_1 && lad[1:0] != `LTI_SZ_2)
              state_reg <= S_SKIP;
            else
              state_reg <= is_rd ? S_TAR1 : S_WDAT;
          end
          S_WDAT: begin
            data_reg <= {lad, data_reg[7:4]};
            nib_reg <= nib_reg + 3'h1;
            if (nib_reg[0]) begin
              nib_reg <= 3'h0;
              state_reg <= S_TAR1;
            end
          end
          S_TAR1: begin
            nib_reg <= nib_reg + 3'h1;
            if (nib_reg[0]) begin
              nib_reg <= 3'h0;
              due_reg <= 2'h0;
              // one wait pattern fixed for the cycle
              wait_pat_reg <= is_dma ? `LTI_SYNC_SHORT : `LTI_SYNC_LONG;
              if (is_rd)
                reg_rd <= 1'b1;
              else begin
                reg_wdata <= data_reg;
                reg_wr <= 1'b1;
              end
              state_reg <= S_SYNC;
            end
          end
          S_SYNC: begin
            lad_oe <= 1'b1;
            if (reg_ready) begin
              lad_out <= `LTI_SYNC_READY;
              data_reg <= reg_rdata;
              state_reg <= is_rd ? S_RDAT : S_TARB;
            end else begin
              // wait sync driven from the first sync clock, well inside the due window
              lad_out <= wait_pat_reg;
              if (due_reg != 2'd`LTI_SYNC_DUE_MAX)
                due_reg <= due_reg + 2'h1;
            end
          end
          S_RDAT: begin
            lad_out <= nib_reg[0] ? data_reg[7:4] : data_reg[3:0];
            nib_reg <= nib_reg + 3'h1;
            if (nib_reg[0]) begin
              nib_reg <= 3'h0;
              state_reg <= S_TARB;
            end
          end
          S_TARB: begin
            if (is_dma && size_reg == `LTI_SZ_2 && byte_reg == 2'h0) begin
              // second byte of a two-byte DMA transfer
              byte_reg <= 2'h1;
              lad_oe <= 1'b0;
              reg_addr <= reg_addr + 16'h0001;
              // device-sourced byte needs a fresh fetch and sync; host-sourced sends data
              state_reg <= is_rd ? S_TAR1 : S_WDAT;
              if (is_rd) begin
                nib_reg <= 3'h1;
              end
            end else begin
              lad_out <= `LTI_TAR;
              state_reg <= S_TAR2;
            end
          end
          S_TAR2: begin
            lad_oe <= 1'b0;
            state_reg <= S_IDLE;
          end
          S_SKIP: lad_oe <= 1'b0;
          default: state_reg <= S_IDLE;
        endcase
      end
    end
  end

  // encoded request: start 0, channel msb first, active bit, then idle high
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ldrq_n <= 1'b1;
      dreq_reg <= 4'h0;
      dreq_cnt_reg <= 3'h0;
      dreq_sent_reg <= 1'b0;
    end else if (!bus_rst_n) begin
      ldrq_n <= 1'b1;
      dreq_cnt_reg <= 3'h0;
      // host forgot the request level in reset, so it is sent again afterwards
      dreq_sent_reg <= 1'b0;
    end else if (!slot_en) begin
      ldrq_n <= ldrq_n;
    end else if (dreq_cnt_reg != 3'h0) begin
      ldrq_n <= dreq_reg[3];
      dreq_reg <= {dreq_reg[2:0], 1'b1};
      dreq_cnt_reg <= dreq_cnt_reg - 3'h1;
    end else if (dma_req != dreq_sent_reg) begin
      ldrq_n <= 1'b0;
      dreq_reg <= {DMA_CHAN, dma_req};
      dreq_sent_reg <= dma_req;
      dreq_cnt_reg <= 3'h4;
    end else
      ldrq_n <= 1'b1;
  end

  // open drain: drive low only, otherwise release
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      power_event_request_n <= 1'b0;
      power_event_oe <= 1'b0;
    end else begin
      power_event_request_n <= 1'b0;
      power_event_oe <= pme_req;
    end
  end
endmodule // lti_target
`default_nettype wire

// *** verif/lti_host.sv ***
`timescale 1ns/1ps
`default_nettype none
module lti_host #(parameter int RST_CYC = 16, parameter int SLOT = 4) (
  input wire logic core_clk,
  input wire logic [3:0] lad_out,
  input wire logic lad_oe,
  output logic lpc_reset_n,
  output logic lframe_n,
  output logic [3:0] lad_in,
  output logic done,
  output logic [11:0] res
);
  logic fr = 1'b1;
  logic hoe = 1'b0;
  logic tog = 1'b0;
  logic [3:0] hl = 4'h0;
  initial lpc_reset_n = 1'b0;
  initial done = 1'b0;
  always @(posedge core_clk) tog <= !tog;
  // released lines toggle so a stale nibble never reads as valid
  assign lframe_n = fr | !lpc_reset_n;
  assign lad_in = lad_oe ? lad_out : (hoe && lpc_reset_n) ? hl : {4{tog}};
  task automatic bus_reset();
    @(posedge core_clk) lpc_reset_n <= 1'b0;
    repeat (RST_CYC) @(posedge core_clk);
    lpc_reset_n <= 1'b1;
    repeat (4) @(posedge core_clk);
  endtask
  task automatic put(input logic [3:0] n, input logic f);
    @(posedge core_clk);
    hl <= n;
    hoe <= 1'b1;
    fr <= f;
    repeat (SLOT - 1) @(posedge core_clk);
  endtask
  task automatic cyc(input logic [3:0] typ, input logic [15:0] a, input logic [7:0] wd,
      input int nb);
    logic [3:0] w;
    logic [7:0] d;
    int t;
    w = 4'hF;
    d = 8'h00;
    put(4'h0, 1'b0);
    put(typ, 1'b1);
    for (int i = 3; i >= 0; i--)
      if (!typ[3] || i < 2) put(a[(typ[3] ? 1 - i : i) * 4 +: 4], 1'b1);
    if (typ == 4'h4) begin
      put(wd[3:0], 1'b1);
      put(wd[7:4], 1'b1);
    end
    put(4'hF, 1'b1);
    @(posedge core_clk) hoe <= 1'b0;
    for (int b = 0; b < nb; b++) begin
      for (t = 0; t < 64 && !(lad_oe && lad_out == 4'h0); t++) begin
        if (lad_oe && w == 4'hF) w = lad_out;
        @(posedge core_clk);
      end
      if (t == 64) begin
        if (w == 4'hF) w = 4'hE;
        break;
      end
      if (typ[3] == typ[2]) begin
        repeat (SLOT) @(posedge core_clk);
        d[3:0] = lad_out;
        repeat (SLOT) @(posedge core_clk);
        d[7:4] = lad_out;
      end
      @(posedge core_clk);
    end
    repeat (2 * SLOT) @(posedge core_clk);
    res <= {w, d};
    done <= 1'b1;
    @(posedge core_clk) done <= 1'b0;
  endtask
endmodule // lti_host
`default_nettype wire

// *** verif/lti_target_assertions.sv ***
`timescale 1ns/1ps
`default_nettype none
module lti_chk (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic lpc_reset_n,
  input wire logic [3:0] lad_out,
  input wire logic lad_oe,
  input wire logic ldrq_n,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic reg_ready,
  input wire logic pme_req,
  input wire logic power_event_request_n,
  input wire logic power_event_oe
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  // six cycles leave room for the pin sampler and the output flop
  a_reset_float: assert property (!lpc_reset_n [*6] |-> !lad_oe)
    else $error("lines driven in bus reset");
  a_reset_req: assert property (!lpc_reset_n [*6] |-> ldrq_n)
    else $error("request active in bus reset");
  a_wait_driven: assert property (lad_oe && lad_out inside {4'h5, 4'h6} |=> lad_oe)
    else $error("wait not followed by drive");
  a_long_hold:
    assert property ($past(lad_oe) && $past(lad_out) == 4'h6 && lad_oe && lad_out == 4'h6
      && !reg_ready |=> lad_oe && lad_out == 4'h6) else $error("long wait broken");
  a_short_hold:
    assert property ($past(lad_oe) && $past(lad_out) == 4'h5 && lad_oe && lad_out == 4'h5
      && !reg_ready |=> lad_oe && lad_out == 4'h5) else $error("short wait broken");
  a_pme_level: assert property (power_event_oe |-> !power_event_request_n)
    else $error("wake output not pulled low");
  a_pme_follow: assert property ($rose(pme_req) |-> ##[1:3] power_event_oe)
    else $error("wake output missing");
  a_strobe_pulse: assert property (reg_wr |=> !reg_wr)
    else $error("write strobe too long");
  a_rw_excl: assert property (!(reg_wr && reg_rd))
    else $error("read and write together");
endmodule // lti_chk
bind lti_target lti_chk i_chk (.*);
`default_nettype wire

// *** verif/tb_lti_target.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_lti_target;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic lpc_reset_n, lframe_n, done, lad_oe, ldrq_n, reg_wr, reg_rd, reg_dma;
  logic power_event_request_n, power_event_oe;
  logic [3:0] lad_in, lad_out;
  logic [15:0] rt_base = 16'h0A00;
  logic [15:0] key_base = 16'h0B00;
  logic dma_req = 1'b0, dma_size2 = 1'b0, dma_dir_wr = 1'b1, pme_req = 1'b0, reg_ready = 1'b0;
  logic [7:0] reg_rdata = 8'h00, reg_wdata;
  logic [15:0] reg_addr;
  logic [1:0] reg_sel;
  logic [11:0] res;
  logic [31:0] rnd = 32'hD42F;
  logic [3:0] dly = 4'h0;
  logic [11:0] rq[$], wq[$];
  int error_cnt = 0, tests_run = 0;
  lti_target #(.DMA_CHAN(3'd2)) i_dut (.*);
  lti_host #(.RST_CYC(16)) i_host (.*);
  always #4 core_clk = !core_clk;
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  task automatic chk(input logic [11:0] got, input logic [11:0] want);
    tests_run++;
    if (got !== want) begin
      error_cnt++;
      $display("Error t=%0t got %h exp %h", $time, got, want);
    end
  endtask
  task automatic test_done();
    $display("checks %0d errors %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // register side answers a few cycles late so waits must appear
  always @(posedge core_clk) begin
    if (reg_rd || reg_wr) dly <= 4'd4 + {2'b00, rnd[1:0]};
    else if (dly != 4'd0) dly <= dly - 4'd1;
    reg_ready <= (dly == 4'd1) | (reg_ready & lframe_n & !(reg_rd | reg_wr));
  end
  always @(posedge core_clk) begin
    if (reg_wr) chk({2'b00, reg_sel, reg_wdata}, wq.pop_front());
    if (done) chk(res, rq.pop_front());
  end
  // data nibbles keep bit 3 set so they never look like a wait code
  task automatic op(input logic [3:0] typ, input logic [15:0] a, input logic [3:0] w,
      input logic [1:0] sel, input int nb);
    logic [7:0] d;
    rnd = lfsr(rnd);
    d = rnd[7:0] | 8'h88;
    reg_rdata <= d;
    if (typ == 4'h4 && w != 4'hE) wq.push_back({2'b00, sel, d});
    rq.push_back({w, (typ[3] == typ[2] && w != 4'hE) ? d : 8'h00});
    i_host.cyc(typ, a, d, nb);
  endtask
  initial begin
    repeat (20000) @(posedge core_clk);
    error_cnt++;
    test_done();
  end
  initial begin
    logic [15:0] a;
    int k;
    repeat (4) @(posedge core_clk);
    rst <= 1'b0;
    i_host.bus_reset();
    op(4'h4, 16'h0A00, 4'h6, 2'd1, 1);
    op(4'h4, 16'h0A7F, 4'h6, 2'd1, 1);
    op(4'h4, 16'h0B1F, 4'h6, 2'd2, 1);
    op(4'h4, 16'h0060, 4'h6, 2'd3, 1);
    op(4'h0, 16'h0064, 4'h6, 2'd3, 1);
    op(4'h0, 16'h0A80, 4'hE, 2'd0, 1);
    op(4'h0, 16'h0B20, 4'hE, 2'd0, 1);
    op(4'h5, 16'h0A00, 4'hE, 2'd0, 1);
    a = {4'h1, rnd[11:7], 7'h00};
    rt_base <= a;
    op(4'h4, a + 16'h0045, 4'h6, 2'd1, 1);
    op(4'h0, 16'h0A00, 4'hE, 2'd0, 1);
    dma_req <= 1'b1;
    for (k = 0; k < 64 && ldrq_n; k++) @(posedge core_clk);
    chk({11'h000, ldrq_n}, 12'h000);
    op(4'hC, 16'h0002, 4'h5, 2'd0, 1);
    dma_size2 <= 1'b1;
    op(4'hC, 16'h0012, 4'h5, 2'd0, 2);
    op(4'hC, 16'h0032, 4'hE, 2'd0, 1);
    op(4'hC, 16'h0001, 4'hE, 2'd0, 1);
    fork
      i_host.bus_reset();
      begin
        repeat (8) @(posedge core_clk);
        chk({10'h000, ldrq_n, lad_oe}, 12'h002);
      end
    join
    dma_req <= 1'b0;
    op(4'h0, a + 16'h0001, 4'h6, 2'd1, 1);
    pme_req <= 1'b1;
    repeat (4) @(posedge core_clk);
    chk({10'h000, power_event_oe, power_event_request_n}, 12'h002);
    pme_req <= 1'b0;
    repeat (5) @(posedge core_clk);
    test_done();
  end
endmodule // tb_lti_target
`default_nettype wire
